// file: common/sbi_pkg.sv
// Register map, field positions and carrier types for the serial bus interface
`default_nettype none
package sbi_pkg;
  // Printed offsets are not multiples of four: they are indices, byte address = 4 * index
  localparam logic [31:0] IDX_DATA_BUFFER   = 32'hFFFFF241;
  localparam logic [31:0] IDX_OWN_ADDRESS   = 32'hFFFFF242;
  localparam logic [31:0] IDX_BUS_STATUS    = 32'hFFFFF243;
  localparam logic [31:0] IDX_IDLE_CONTROL  = 32'hFFFFF244;
  localparam logic [31:0] IDX_CLOCK_CONTROL = 32'hFFFFF245;
  localparam logic [31:0] IDX_IRQ_STATUS    = 32'hFFFFF246;
  localparam logic [31:0] IDX_IRQ_MASK      = 32'hFFFFF247;
  localparam logic [11:0] ADDR_LOW_BITS     = 12'hFFF;

  // Bit positions
  localparam int BIT_MASTER   = 7;
  localparam int BIT_TRANSMIT = 6;
  localparam int BIT_BUSY     = 5;
  localparam int BIT_PENDING  = 4;
  localparam int BIT_ARB_LOST = 3;
  localparam int BIT_ADDRESSED = 2;
  localparam int BIT_GENCALL  = 1;
  localparam int BIT_LASTBIT  = 0;
  localparam int BIT_IDLE_RUN = 6;
  localparam int BIT_CLK_RUN  = 7;
  localparam int BIT_CMP_OFF  = 0;

  // Interrupt status bits
  localparam int EV_WORD    = 0;
  localparam int EV_ARB     = 1;
  localparam int EV_ADDR    = 2;
  localparam int EV_STOP    = 3;
  localparam int EV_COUNT   = 4;

  localparam logic [7:0] RESET_ZERO    = 8'h00;
  localparam logic [7:0] GENERAL_CALL  = 8'h00;
  localparam int         DIVIDE_BY     = 4;

  // Bus pin levels sampled together; edges come from comparing with the previous sample
  typedef struct packed {
    logic scl;
    logic sda;
  } pins_t;

  // Bus observer events
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } bus_ev_t;

  typedef enum {ST_IDLE, ST_SHIFT, ST_ACK, ST_HOLD} xfer_state_t;
endpackage : sbi_pkg
`default_nettype wire

// file: hdl/sbi_status_regs.sv
// Serial bus interface: APB registers, status flags and byte engine
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Status reads, control writes share one address
// - Status shows busy, master, transmit bits
// - Pending bit zero while request outstanding, resets one
// - Arbitration loss sets its flag
// - Address match or general call flagged
// - Last received data bit kept
// - Idle bit chooses halt or run
// - Clock run bit gates internal clock
// - Buffer sends bit seven first, returns received
// - Mode bit zero enables address compare
// - Pending clears per word, holds clock, buffer access sets
// - Start sets busy, stop clears busy
module sbi_status_regs
  import sbi_pkg::*;
#(
  parameter int DIV = DIVIDE_BY
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        IDLE_MODE,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SCL_OE,
  output logic             SDA_OE,
  output logic             IRQ
);
  // Divider counter is eight bits wide
  if (DIV < 2 || DIV > 256) begin : g_div_check
    $error("DIV must lie between 2 and 256");
  end

  // Control and status state
  logic        master_select, transmit_select, bus_busy_flag, pending;
  logic        arbitration_lost_flag, addressed_as_slave_flag, general_call_flag;
  logic        last_received_bit, idle_run_enable, baud_clock_run;
  logic [7:0]  own_address, tx_data, rx_data, shift;
  logic [3:0]  bit_cnt;
  logic [EV_COUNT-1:0] irq_status, irq_mask;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, irq_q, scl_oe_q, sda_oe_q;
  pins_t       pins_d;
  logic [7:0]  div_cnt;
  xfer_state_t state;
  logic        addr_phase;

  logic        next_master, next_transmit, next_busy, next_pending;
  logic        next_arb, next_addressed, next_gencall, next_lastbit;
  logic        next_idle_run, next_clk_run;
  logic [7:0]  next_own_address, next_tx_data, next_rx_data, next_shift;
  logic [3:0]  next_bit_cnt;
  logic [EV_COUNT-1:0] next_irq_status, next_irq_mask;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_irq, next_scl_oe, next_sda_oe;
  logic [7:0]  next_div_cnt;
  xfer_state_t next_state;
  logic        next_addr_phase;

  // Decode helpers
  logic [31:0] idx;
  logic        access, wr, rd, run, tick;
  bus_ev_t     ev;
  logic [EV_COUNT-1:0] events;

  assign idx    = {2'b00, PADDR[31:2]} | 32'hC0000000;
  assign access = PSEL && PENABLE && !pready_q;
  assign wr     = access && PWRITE;
  assign rd     = access && !PWRITE;
  // Interface halts in idle power mode unless told to run
  assign run    = baud_clock_run && (!IDLE_MODE || idle_run_enable);
  assign tick   = run && (div_cnt == 8'(DIV - 1));
  // One driver for the whole event word
  assign ev = '{start: pins_d.scl && SCL_IN && pins_d.sda && !SDA_IN,
                stop:  pins_d.scl && SCL_IN && !pins_d.sda && SDA_IN,
                rise:  !pins_d.scl && SCL_IN,
                fall:  pins_d.scl && !SCL_IN};

  // Next state for registers, flags and byte engine
  always_comb begin
    next_master     = master_select;
    next_transmit   = transmit_select;
    next_busy       = bus_busy_flag;
    next_pending    = pending;
    next_arb        = arbitration_lost_flag;
    next_addressed  = addressed_as_slave_flag;
    next_gencall    = general_call_flag;
    next_lastbit    = last_received_bit;
    next_idle_run   = idle_run_enable;
    next_clk_run    = baud_clock_run;
    next_own_address = own_address;
    next_tx_data    = tx_data;
    next_rx_data    = rx_data;
    next_shift      = shift;
    next_bit_cnt    = bit_cnt;
    next_irq_mask   = irq_mask;
    next_state      = state;
    next_addr_phase = addr_phase;
    next_div_cnt    = run ? (tick ? 8'h00 : div_cnt + 8'h01) : 8'h00;
    next_sda_oe     = sda_oe_q;
    events          = '0;
    next_prdata     = prdata_q;
    next_pslverr    = 1'b0;
    next_pready     = access;

    // Register writes; status address writes reach control two
    if (wr) begin
      if (idx == IDX_DATA_BUFFER) begin
        next_tx_data = PWDATA[7:0];
        next_pending = 1'b1;
      end else if (idx == IDX_OWN_ADDRESS) begin
        next_own_address = PWDATA[7:0];
      end else if (idx == IDX_BUS_STATUS) begin
        next_master   = PWDATA[BIT_MASTER];
        next_transmit = PWDATA[BIT_TRANSMIT];
        if (PWDATA[BIT_PENDING]) next_pending = 1'b1;
      end else if (idx == IDX_IDLE_CONTROL) begin
        next_idle_run = PWDATA[BIT_IDLE_RUN];
      end else if (idx == IDX_CLOCK_CONTROL) begin
        next_clk_run = PWDATA[BIT_CLK_RUN];
      end else if (idx == IDX_IRQ_MASK) begin
        next_irq_mask = PWDATA[EV_COUNT-1:0];
      end else if (idx != IDX_IRQ_STATUS) begin
        next_pslverr = 1'b1;
      end
    end

    // Register reads; only a buffer read has a side effect
    if (rd) begin
      next_prdata = 32'h00000000;
      if (idx == IDX_DATA_BUFFER) begin
        next_prdata[7:0] = rx_data;
        next_pending = 1'b1;
      end else if (idx == IDX_BUS_STATUS) begin
        next_prdata[7:0] = {master_select, transmit_select, bus_busy_flag, pending,
                            arbitration_lost_flag, addressed_as_slave_flag,
                            general_call_flag, last_received_bit};
      end else if (idx == IDX_IDLE_CONTROL) begin
        next_prdata[BIT_IDLE_RUN] = idle_run_enable;
      end else if (idx == IDX_CLOCK_CONTROL) begin
        next_prdata[BIT_CLK_RUN] = baud_clock_run;
      end else if (idx == IDX_IRQ_STATUS) begin
        next_prdata[EV_COUNT-1:0] = irq_status;
      end else if (idx == IDX_IRQ_MASK) begin
        next_prdata[EV_COUNT-1:0] = irq_mask;
      end else if (idx != IDX_OWN_ADDRESS) begin
        next_pslverr = 1'b1;
      end
    end

    // Bus observer works whenever the clock runs
    if (run) begin
      if (ev.start) begin
        next_busy       = 1'b1;
        next_state      = ST_SHIFT;
        next_bit_cnt    = 4'h0;
        next_addr_phase = 1'b1;
        next_addressed  = 1'b0;
        next_gencall    = 1'b0;
        next_arb        = 1'b0;
        next_shift      = master_select ? tx_data : RESET_ZERO;
      end else if (ev.stop) begin
        next_busy     = 1'b0;
        next_master   = 1'b0;
        next_transmit = 1'b0;
        next_state    = ST_IDLE;
        next_sda_oe   = 1'b0;
        events[EV_STOP] = 1'b1;
      end else begin
        case (state)
          ST_SHIFT: begin
            // Drive MSB first on the low phase
            if (!SCL_IN && transmit_select) next_sda_oe = !shift[7];
            if (ev.rise) begin
              next_lastbit = SDA_IN;
              if (transmit_select && shift[7] && !SDA_IN) begin
                next_arb    = 1'b1;
                next_master = 1'b0;
                next_transmit = 1'b0;
                next_sda_oe = 1'b0;
                events[EV_ARB] = 1'b1;
              end
              next_shift   = {shift[6:0], SDA_IN};
              next_bit_cnt = bit_cnt + 4'h1;
            end
            if (ev.fall && bit_cnt == 4'h8) begin
              next_state  = ST_ACK;
              next_sda_oe = 1'b0;
              next_rx_data = shift;
              if (addr_phase && !master_select) begin
                // Compare only in recognition mode
                if (!own_address[BIT_CMP_OFF] &&
                    shift[7:1] == own_address[7:1]) begin
                  next_addressed = 1'b1;
                  next_transmit  = shift[0];
                end else if (shift == GENERAL_CALL) begin
                  next_addressed = 1'b1;
                  next_gencall   = 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (ev.fall) begin
              next_addr_phase = 1'b0;
              if (master_select || addressed_as_slave_flag) begin
                next_pending = 1'b0;
                events[EV_WORD] = 1'b1;
                events[EV_ADDR] = addr_phase && addressed_as_slave_flag;
                next_state = ST_HOLD;
              end else begin
                next_state = ST_IDLE;
              end
            end
          end
          ST_HOLD: begin
            if (pending) begin
              next_state   = ST_SHIFT;
              next_bit_cnt = 4'h0;
              next_shift   = tx_data;
            end
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end
    end

    // Hardware set wins over write-one clear
    next_irq_status = irq_status;
    if (wr && idx == IDX_IRQ_STATUS) next_irq_status = irq_status & ~PWDATA[EV_COUNT-1:0];
    next_irq_status = next_irq_status | events;
    next_irq        = |(next_irq_status & next_irq_mask);
    next_scl_oe     = !next_pending && next_state == ST_HOLD;
  end

  // Register stage
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      master_select <= 1'b0;
      transmit_select <= 1'b0;
      bus_busy_flag <= 1'b0;
      pending <= 1'b1;
      arbitration_lost_flag <= 1'b0;
      addressed_as_slave_flag <= 1'b0;
      general_call_flag <= 1'b0;
      last_received_bit <= 1'b0;
      idle_run_enable <= 1'b0;
      baud_clock_run <= 1'b0;
      own_address <= RESET_ZERO;
      tx_data <= RESET_ZERO;
      rx_data <= RESET_ZERO;
      shift <= RESET_ZERO;
      bit_cnt <= 4'h0;
      irq_status <= '0;
      irq_mask <= '0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      pins_d <= '{scl: 1'b1, sda: 1'b1};
      div_cnt <= 8'h00;
      state <= ST_IDLE;
      addr_phase <= 1'b0;
    end else begin
      master_select <= next_master;
      transmit_select <= next_transmit;
      bus_busy_flag <= next_busy;
      pending <= next_pending;
      arbitration_lost_flag <= next_arb;
      addressed_as_slave_flag <= next_addressed;
      general_call_flag <= next_gencall;
      last_received_bit <= next_lastbit;
      idle_run_enable <= next_idle_run;
      baud_clock_run <= next_clk_run;
      own_address <= next_own_address;
      tx_data <= next_tx_data;
      rx_data <= next_rx_data;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      prdata_q <= next_prdata;
      pready_q <= next_pready;
      pslverr_q <= next_pslverr;
      irq_q <= next_irq;
      scl_oe_q <= next_scl_oe;
      sda_oe_q <= next_sda_oe;
      pins_d <= '{scl: SCL_IN, sda: SDA_IN};
      div_cnt <= next_div_cnt;
      state <= next_state;
      addr_phase <= next_addr_phase;
    end
  end

  assign PRDATA  = prdata_q;
  assign PREADY  = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ     = irq_q;
  assign SCL_OE  = scl_oe_q;
  assign SDA_OE  = sda_oe_q;

  // Checks
  AST_PENDING_RESET: assert property (@(posedge CORE_CLK) $fell(SYS_RST) |-> pending)
    else $error("pending not one after reset");
  AST_BUSY_START: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && ev.start |=> bus_busy_flag) else $error("start did not set busy");
  AST_BUSY_STOP: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && ev.stop && !ev.start |=> !bus_busy_flag) else $error("stop did not clear busy");
  AST_BUF_SETS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    access && idx == IDX_DATA_BUFFER |=> pending) else $error("buffer access left pending low");
  AST_READ_KEEPS: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    rd && idx == IDX_BUS_STATUS && !run |=> $stable(irq_status) && $stable(bus_busy_flag))
    else $error("status read changed flags");
  AST_STATUS_READ: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    rd && idx == IDX_BUS_STATUS |=> PRDATA[BIT_PENDING] == $past(pending))
    else $error("status read wrong");
  AST_HALT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !baud_clock_run |=> div_cnt == 8'h00) else $error("clock ran while stopped");
  AST_LASTBIT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    run && state == ST_SHIFT && ev.rise && !ev.start && !ev.stop |=>
    last_received_bit == $past(SDA_IN)) else $error("last bit not kept");
  AST_READY: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    PSEL && PENABLE && !PREADY |=> PREADY) else $error("no ready");
  COV_WRITE: cover property (@(posedge CORE_CLK) wr && idx == IDX_BUS_STATUS);
  COV_ADDR: cover property (@(posedge CORE_CLK) $rose(addressed_as_slave_flag));
  COV_ARB: cover property (@(posedge CORE_CLK) $rose(arbitration_lost_flag));
  COV_IRQ: cover property (@(posedge CORE_CLK) $rose(IRQ));
  COV_TICK: cover property (@(posedge CORE_CLK) tick);
endmodule : sbi_status_regs
`default_nettype wire

// file: test/i2c_master_model.sv
// Behavioural far-side I2C master with open-drain drivers
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
  input  wire logic CORE_CLK,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // Both lines released at time zero, pull-ups hold them high
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // A third of a bit, slow enough for the synchronous pin sampling
  task automatic hc();
    repeat (4) @(posedge CORE_CLK);
  endtask : hc

  // Release clock, wait while the device stretches it; the bench watchdog ends a hang
  task automatic rise();
    scl_low <= 1'b0;
    @(posedge CORE_CLK);
    while (scl !== 1'b1) @(posedge CORE_CLK);
    hc();
  endtask : rise

  // Data falls while clock is high
  task automatic start_cond();
    sda_low <= 1'b1;
    hc();
    scl_low <= 1'b1;
    hc();
  endtask : start_cond

  // Data rises while clock is high
  task automatic stop_cond();
    sda_low <= 1'b1;
    hc();
    rise();
    sda_low <= 1'b0;
    hc();
  endtask : stop_cond

  // Byte out, most significant bit first, then the ack slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      hc();
      rise();
      scl_low <= 1'b1;
      hc();
    end
    sda_low <= 1'b0;
    hc();
    rise();
    ack = sda;
    scl_low <= 1'b1;
    hc();
  endtask : send_byte

  // Byte in, sampled on clock high, then a not-acknowledge
  task automatic recv_byte(output logic [7:0] b);
    sda_low <= 1'b0;
    b = 8'h00;
    for (int i = 0; i < 8; i++) begin
      hc();
      rise();
      b = {b[6:0], sda};
      scl_low <= 1'b1;
    end
    hc();
    rise();
    scl_low <= 1'b1;
    hc();
  endtask : recv_byte
endmodule : i2c_master_model
`default_nettype wire

// file: test/serial_bus_status_and_config_regs_tb.sv
// Register-level testbench for the serial bus interface
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin \
  $display("unexpected %s expected %h seen %h", name, exp, got); num_errors++; end end
module serial_bus_status_and_config_regs_tb;
  import sbi_pkg::*;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] paddr    = 32'h00000000;
  logic [31:0] pwdata   = 32'h00000000;
  logic        idle_mode = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_oe;
  logic        sda_oe;
  logic        irq;
  logic        m_scl_low;
  logic        m_sda_low;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  // Wired-AND lines with pull-ups
  wire scl_line = ~(m_scl_low | scl_oe);
  wire sda_line = ~(m_sda_low | sda_oe);

  sbi_status_regs #(.DIV(DIVIDE_BY)) sbi_status_regs_inst (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IDLE_MODE(idle_mode), .SCL_IN(scl_line),
    .SDA_IN(sda_line), .SCL_OE(scl_oe), .SDA_OE(sda_oe), .IRQ(irq)
  );
  i2c_master_model i2c_master_model_inst (
    .CORE_CLK(core_clk), .scl(scl_line), .sda(sda_line),
    .scl_low(m_scl_low), .sda_low(m_sda_low)
  );

  // 20 MHz clock
  always #25 core_clk = ~core_clk;

  task automatic test_done();
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // Hang guard, far above the fewer than a thousand cycles needed
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end

  // One APB transfer; response taken at the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx[29:0], 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    // Read right after the edge: flops have not updated yet, so these are sampled values
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  // Masked register compare
  task automatic rd(input logic [31:0] idx, input logic [7:0] m, input logic [7:0] x,
                    input string name);
    logic [7:0] r;
    logic       e;
    apb(1'b0, idx, 8'h00, r, e);
    `CHK(name, x, r & m)
  endtask : rd

  task automatic chk_irq(input logic x);
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK("irq", x, irq)
  endtask : chk_irq

  // Main sequence
  initial begin
    logic [7:0] r;
    logic       e;
    logic       ack;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(IDX_BUS_STATUS, 8'hFF, 8'h10, "status reset");
    rd(IDX_CLOCK_CONTROL, 8'h80, 8'h00, "clock run reset");
    rd(IDX_IDLE_CONTROL, 8'h40, 8'h00, "idle run reset");
    rd(IDX_OWN_ADDRESS, 8'hFF, 8'h00, "own address");
    apb(1'b0, 32'hFFFFF248, 8'h00, r, e);
    `CHK("unmapped error", 1'b1, e)
    wr(IDX_BUS_STATUS, 8'h0F);
    rd(IDX_BUS_STATUS, 8'hFF, 8'h10, "status after control write");
    // Internal clock stopped: bus start unseen
    i2c_master_model_inst.start_cond();
    rd(IDX_BUS_STATUS, 8'h20, 8'h00, "busy clock stopped");
    i2c_master_model_inst.stop_cond();
    wr(IDX_CLOCK_CONTROL, 8'h80);
    rd(IDX_CLOCK_CONTROL, 8'h80, 8'h80, "clock run");
    @(posedge core_clk);
    idle_mode <= 1'b1;
    i2c_master_model_inst.start_cond();
    rd(IDX_BUS_STATUS, 8'h20, 8'h00, "busy in idle halt");
    i2c_master_model_inst.stop_cond();
    wr(IDX_IDLE_CONTROL, 8'h40);
    rd(IDX_IDLE_CONTROL, 8'h40, 8'h40, "idle run");
    wr(IDX_OWN_ADDRESS, 8'h54);
    // Addressed write: own address 0x2A, compare mode
    i2c_master_model_inst.start_cond();
    rd(IDX_BUS_STATUS, 8'h20, 8'h20, "busy after start");
    i2c_master_model_inst.send_byte(8'h54, ack);
    // Acknowledge is not generated by this block, so the slot stays released
    `CHK("ack slot released", 1'b1, ack)
    rd(IDX_BUS_STATUS, 8'hFF, 8'h24, "status addressed");
    chk_irq(1'b0);
    wr(IDX_IRQ_MASK, 8'h04);
    chk_irq(1'b1);
    wr(IDX_IRQ_STATUS, 8'h04);
    chk_irq(1'b0);
    rd(IDX_DATA_BUFFER, 8'hFF, 8'h54, "buffer address");
    rd(IDX_BUS_STATUS, 8'h10, 8'h10, "pending after read");
    i2c_master_model_inst.send_byte(8'hA5, ack);
    rd(IDX_BUS_STATUS, 8'h31, 8'h21, "status data byte");
    rd(IDX_DATA_BUFFER, 8'hFF, 8'hA5, "buffer data");
    i2c_master_model_inst.stop_cond();
    rd(IDX_BUS_STATUS, 8'h20, 8'h00, "busy after stop");
    // General call
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(8'h00, ack);
    rd(IDX_BUS_STATUS, 8'h37, 8'h26, "status general call");
    rd(IDX_DATA_BUFFER, 8'hFF, 8'h00, "buffer general call");
    i2c_master_model_inst.stop_cond();
    // Addressed read: device transmits from the buffer
    i2c_master_model_inst.start_cond();
    i2c_master_model_inst.send_byte(8'h55, ack);
    rd(IDX_BUS_STATUS, 8'h74, 8'h64, "status slave transmit");
    wr(IDX_DATA_BUFFER, 8'hC3);
    i2c_master_model_inst.recv_byte(r);
    `CHK("sent byte", 8'hC3, r)
    // Buffer access lets go of the clock held low after the word
    rd(IDX_DATA_BUFFER, 8'hFF, 8'hC3, "buffer after send");
    i2c_master_model_inst.stop_cond();
    rd(IDX_BUS_STATUS, 8'h20, 8'h00, "busy after last stop");
    test_done();
  end
endmodule : serial_bus_status_and_config_regs_tb
`default_nettype wire
